// ===== src/hbms_device.sv
`timescale 1ns/1ps
// Functional notes
// - strap pins sampled once after reset
// - strap code picks bus personality
// - boot-rom mode loads registers automatically
// - write to 7F changes personality
// - host drives boot rom select itself
// - cs-style bus: address, data, cs, r/w
// - host holds cs until ack falls
// - ack high within 49/182 ns
// - read data valid within 40/192 ns
// - write data taken at cs rising
// - host gap 160 ns after write
// - host gap 15 ns after read
module hbms_device
  import hbms_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  hbms_if.dev                    bus,
  input  wire logic [STRAP_W-1:0] host_if_strap,
  output logic                   bootLoadReq,
  output logic [ADDR_W-1:0]      bootLoadAddr,
  input  wire logic              bootLoadValid,
  input  wire logic [DATA_W-1:0] bootLoadData,
  output logic                   bootDone,
  output logic [STRAP_W-1:0]     activeMode
);
  // ************************************************
  // personality
  // ************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BUSY = 4'h2,
    ST_ACK  = 4'h4,
    ST_WAIT = 4'h8
  } hbms_state_e;

  logic [DATA_W-1:0] regs [NUM_REGS];
  logic              strapTaken_r;
  logic [STRAP_W-1:0] mode_r;
  logic              booting_r;
  logic [ADDR_W-1:0] bootAddr_r;
  hbms_state_e       state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic              lastWrite_r;
  logic              isWrite_r;
  logic [ADDR_W-1:0] accAddr_r;
  logic [DATA_W-1:0] rdData_r;
  logic              csStyle;
  logic              wrCommit;

  // codes with no personality of their own collapse to off
  function automatic logic [STRAP_W-1:0] decodeMode(input logic [STRAP_W-1:0] code);
    return (code > STRAP_SERIAL) ? STRAP_OFF : code;
  endfunction

  assign csStyle      = (mode_r == STRAP_CS_STYLE) && strapTaken_r && !booting_r;
  assign activeMode   = mode_r;
  assign bootDone     = strapTaken_r && !booting_r;
  assign bootLoadReq  = booting_r;
  assign bootLoadAddr = bootAddr_r;

  // strap caught by a clocked process after release
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strapTaken_r <= 1'b0;
    end else begin
      strapTaken_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_r <= MODE_FIELD_RESET;
    end else if (!strapTaken_r) begin
      mode_r <= decodeMode(host_if_strap);
    end else if (wrCommit && accAddr_r == MODE_REG_ADDR) begin
      mode_r <= decodeMode(bus.hostData[STRAP_W-1:0]);
    end else if (booting_r && bootLoadValid && bootAddr_r == MODE_REG_ADDR) begin
      mode_r <= decodeMode(bootLoadData[STRAP_W-1:0]);
    end
  end

  // ************************************************
  // boot rom load
  // ************************************************
  // walks every address once; the rom side paces with bootLoadValid
  always_ff @(posedge core_clk) begin
    if (srst) begin
      booting_r  <= 1'b0;
      bootAddr_r <= '0;
    end else if (!strapTaken_r) begin
      booting_r  <= (host_if_strap == STRAP_BOOT_ROM);
      bootAddr_r <= '0;
    end else if (booting_r && bootLoadValid) begin
      bootAddr_r <= bootAddr_r + 1'b1;
      if (&bootAddr_r) begin
        booting_r <= 1'b0;
      end
    end
  end

  // ************************************************
  // register store
  // ************************************************
  // no reset on the array: contents are defined by boot load or host writes
  always_ff @(posedge core_clk) begin
    if (booting_r && bootLoadValid) begin
      regs[bootAddr_r] <= bootLoadData;
    end else if (wrCommit) begin
      regs[accAddr_r] <= bus.hostData;
    end
  end

  // ************************************************
  // cs-style access engine
  // ************************************************
  // write commits on the cs rising edge, data still held by host
  assign wrCommit = (state_r == ST_WAIT) && isWrite_r && bus.chip_select_n;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r     <= ST_IDLE;
      cnt_r       <= CNT_ZERO;
      isWrite_r   <= 1'b0;
      lastWrite_r <= 1'b0;
      accAddr_r   <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (csStyle && !bus.chip_select_n) begin
            isWrite_r <= !bus.read_write_select;
            accAddr_r <= bus.addr;
            cnt_r     <= lastWrite_r ? ACK_WR_CNT : ACK_RR_CNT;
            state_r   <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (cnt_r <= CNT_ONE) begin
            state_r <= ST_ACK;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        ST_ACK: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (bus.chip_select_n) begin
            lastWrite_r <= isWrite_r;
            state_r     <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData_r <= REG_RESET_VAL;
    end else if (state_r == ST_BUSY && cnt_r <= CNT_ONE) begin
      rdData_r <= regs[accAddr_r];
    end
  end

  // ack: high from cs fall while busy, falls to signal completion
  always_ff @(posedge core_clk) begin
    if (srst) begin
      bus.data_transfer_ack <= 1'b0;
      bus.ackOe_n           <= 1'b1;
      bus.devDataOe_n       <= 1'b1;
      bus.devData           <= REG_RESET_VAL;
    end else begin
      bus.ackOe_n           <= !(csStyle && !bus.chip_select_n);
      bus.data_transfer_ack <= (state_r == ST_IDLE && csStyle && !bus.chip_select_n) ||
                               (state_r == ST_BUSY && cnt_r > CNT_ONE);
      bus.devDataOe_n       <= !(csStyle && !bus.chip_select_n && !isWrite_r &&
                                 (state_r == ST_ACK || state_r == ST_WAIT));
      bus.devData           <= rdData_r;
    end
  end
endmodule

// ===== pkg/hbms_pkg.sv
package hbms_pkg;
  localparam int          CLK_PERIOD_NS     = 4;
  localparam int          ADDR_W            = 7;
  localparam int          DATA_W            = 8;
  localparam int          NUM_REGS          = 128;
  localparam int          STRAP_W           = 3;
  localparam int          CNT_W             = 8;

  // ************************************************
  // strap and personality codes
  // ************************************************
  localparam logic [2:0]  STRAP_SERIAL      = 3'h5;
  localparam logic [2:0]  STRAP_CS_STYLE    = 3'h4;
  localparam logic [2:0]  STRAP_STROBE      = 3'h3;
  localparam logic [2:0]  STRAP_MUXED       = 3'h2;
  localparam logic [2:0]  STRAP_BOOT_ROM    = 3'h1;
  localparam logic [2:0]  STRAP_OFF         = 3'h0;
  localparam logic [6:0]  MODE_REG_ADDR     = 7'h7f;
  localparam logic [2:0]  MODE_FIELD_RESET  = 3'h0;
  localparam logic [7:0]  REG_RESET_VAL     = 8'h00;

  // ************************************************
  // timing
  // ************************************************
  localparam int          ACK_RR_MAX_NS     = 49;
  localparam int          ACK_WR_MAX_NS     = 182;
  localparam int          DATA_RR_MAX_NS    = 40;
  localparam int          DATA_WR_MAX_NS    = 192;
  localparam int          GAP_AFTER_WR_NS   = 160;
  localparam int          GAP_AFTER_RD_NS   = 15;
  // device ack latency chosen inside both data and ack maxima
  localparam int          ACK_RR_CYC        = DATA_RR_MAX_NS / CLK_PERIOD_NS - 2;
  localparam int          ACK_WR_CYC        = ACK_WR_MAX_NS / CLK_PERIOD_NS - 2;
  localparam int          GAP_WR_CYC        = (GAP_AFTER_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_RD_CYC        = (GAP_AFTER_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  ACK_RR_CNT        = 8'(ACK_RR_CYC);
  localparam logic [7:0]  ACK_WR_CNT        = 8'(ACK_WR_CYC);
  localparam logic [7:0]  GAP_WR_CNT        = 8'(GAP_WR_CYC);
  localparam logic [7:0]  GAP_RD_CNT        = 8'(GAP_RD_CYC);
  localparam logic [7:0]  CNT_ZERO          = 8'h00;
  localparam logic [7:0]  CNT_ONE           = 8'h01;
endpackage

// ===== pkg/hbms_if.sv
`timescale 1ns/1ps
interface hbms_if;
  import hbms_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] hostData;
  logic [DATA_W-1:0] devData;
  logic              devDataOe_n;
  logic              chip_select_n;
  logic              read_write_select;
  logic              data_transfer_ack;
  logic              ackOe_n;
  logic              bootRomCs_n;

  modport dev (
    input  addr, hostData, chip_select_n, read_write_select,
    output devData, devDataOe_n, data_transfer_ack, ackOe_n
  );
  modport host (
    output addr, hostData, chip_select_n, read_write_select, bootRomCs_n,
    input  devData, devDataOe_n, data_transfer_ack, ackOe_n
  );
endinterface

// ===== src/hbms_host.sv
`timescale 1ns/1ps
module hbms_host
  import hbms_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  hbms_if.host                   bus,
  input  wire logic              reqValid,
  output logic                   reqReady,
  input  wire logic              reqWrite,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [DATA_W-1:0] reqData,
  input  wire logic              romSelect,
  output logic                   rspValid,
  output logic [DATA_W-1:0]      rspData
);
  typedef enum logic [3:0] {
    HS_IDLE  = 4'h1,
    HS_WAIT  = 4'h2,
    HS_HOLD  = 4'h4,
    HS_GAP   = 4'h8
  } hbms_hstate_e;

  hbms_hstate_e     state_r;
  logic [CNT_W-1:0] gap_r;
  logic             sawAck_r;
  logic             wr_r;

  assign reqReady = (state_r == HS_IDLE);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r               <= HS_IDLE;
      gap_r                 <= CNT_ZERO;
      sawAck_r              <= 1'b0;
      wr_r                  <= 1'b0;
      bus.chip_select_n     <= 1'b1;
      bus.read_write_select <= 1'b1;
      bus.addr              <= '0;
      bus.hostData          <= REG_RESET_VAL;
      bus.bootRomCs_n       <= 1'b1;
      rspValid              <= 1'b0;
      rspData               <= REG_RESET_VAL;
    end else begin
      rspValid        <= 1'b0;
      // rom only selected while the device bus stays quiet next cycle
      bus.bootRomCs_n <= !(romSelect && state_r == HS_IDLE && !reqValid);
      case (state_r)
        HS_IDLE: begin
          if (reqValid) begin
            bus.addr              <= reqAddr;
            bus.hostData          <= reqData;
            bus.read_write_select <= !reqWrite;
            bus.chip_select_n     <= 1'b0;
            wr_r                  <= reqWrite;
            sawAck_r              <= 1'b0;
            state_r               <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!bus.ackOe_n && bus.data_transfer_ack) begin
            sawAck_r <= 1'b1;
          end
          if (sawAck_r && !bus.ackOe_n && !bus.data_transfer_ack) begin
            state_r <= HS_HOLD;
          end
        end
        HS_HOLD: begin
          if (!wr_r) begin
            rspData  <= bus.devData;
            rspValid <= 1'b1;
          end
          // data stays on the lines past cs rise, until the next request is taken in HS_IDLE
          bus.chip_select_n <= 1'b1;
          gap_r             <= wr_r ? GAP_WR_CNT : GAP_RD_CNT;
          state_r           <= HS_GAP;
        end
        HS_GAP: begin
          if (gap_r <= CNT_ONE) begin
            state_r <= HS_IDLE;
          end else begin
            gap_r <= gap_r - CNT_ONE;
          end
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== dv/hbms_props.sv
`timescale 1ns/1ps
module hbms_props
  import hbms_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              srst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] hostData,
  input wire logic [DATA_W-1:0] devData,
  input wire logic              devDataOe_n,
  input wire logic              chip_select_n,
  input wire logic              read_write_select,
  input wire logic              data_transfer_ack,
  input wire logic              ackOe_n,
  input wire logic              bootRomCs_n
);
  localparam int RR_MAX = 12;
  localparam int WR_MAX = 45;
  logic       curWr_r;
  logic       prevWr_r;
  logic [7:0] gap_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****
  // access history
  // ****
  always_ff @(posedge core_clk) begin
    if (!chip_select_n) curWr_r <= !read_write_select;
  end
  always_ff @(posedge core_clk) begin
    if (srst) prevWr_r <= 1'b0;
    else if ($rose(chip_select_n)) prevWr_r <= curWr_r;
  end
  // saturates so the first access after reset is never judged too early
  always_ff @(posedge core_clk) begin
    if (srst) gap_r <= 8'hff;
    else if (!chip_select_n) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end
  // ****
  // properties
  // ****
  sequence s_ack_up;
    data_transfer_ack && $past(!chip_select_n);
  endsequence
  sequence s_ack_start;
    $rose(data_transfer_ack);
  endsequence
  property p_ack_start; $fell(ackOe_n) |-> s_ack_up; endproperty
  property p_ack_rr; s_ack_start ##0 !prevWr_r |-> ##[1:RR_MAX] !data_transfer_ack; endproperty
  property p_ack_wr; s_ack_start ##0 prevWr_r |-> ##[1:WR_MAX] !data_transfer_ack; endproperty
  // data enable is registered off the same state step that drops ack, so it shows one edge later
  property p_rd_data; $fell(data_transfer_ack) && read_write_select && !chip_select_n |=> !devDataOe_n; endproperty
  property p_cs_hold; data_transfer_ack && !ackOe_n |-> !chip_select_n; endproperty
  property p_stable;
    !chip_select_n && $past(!chip_select_n) |-> $stable(hostData) && $stable(addr) && $stable(read_write_select);
  endproperty
  property p_release; $rose(chip_select_n) |=> ackOe_n && devDataOe_n; endproperty
  property p_gap_wr; $fell(chip_select_n) && prevWr_r |-> gap_r >= GAP_WR_CNT; endproperty
  property p_gap_rd; $fell(chip_select_n) && !prevWr_r |-> gap_r >= GAP_RD_CNT; endproperty
  property p_rom_cs; !bootRomCs_n |-> chip_select_n; endproperty
  a_ack_start: assert property (p_ack_start) else $error("ack not raised in access");
  a_ack_rr: assert property (p_ack_rr) else $error("ack too long after read");
  a_ack_wr: assert property (p_ack_wr) else $error("ack too long after write");
  a_rd_data: assert property (p_rd_data) else $error("read data not driven");
  a_cs_hold: assert property (p_cs_hold) else $error("select released early");
  a_stable: assert property (p_stable) else $error("request changed in access");
  a_release: assert property (p_release) else $error("outputs not released");
  a_gap_wr: assert property (p_gap_wr) else $error("gap after write short");
  a_gap_rd: assert property (p_gap_rd) else $error("gap after read short");
  a_rom_cs: assert property (p_rom_cs) else $error("rom and device selected");
endmodule

// ===== dv/host_bus_mode_select_port_bench.sv
`timescale 1ns/1ps
module host_bus_mode_select_port_bench import hbms_pkg::*;;
  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  logic [STRAP_W-1:0] strap = STRAP_CS_STYLE;
  logic               reqValid = 1'b0;
  logic               reqWrite = 1'b0;
  logic               romSelect = 1'b0;
  logic               bootLoadValid = 1'b0;
  logic [ADDR_W-1:0]  reqAddr = '0;
  logic [DATA_W-1:0]  reqData = '0;
  logic [DATA_W-1:0]  bootLoadData = '0;
  logic [DATA_W-1:0]  rdData;
  logic [DATA_W-1:0]  rspData;
  logic [ADDR_W-1:0]  bootLoadAddr;
  logic [STRAP_W-1:0] activeMode;
  logic               reqReady, rspValid, bootLoadReq, bootDone;
  int                 n_mismatch = 0;
  int                 cmp_count = 0;
  int                 cycles = 0;
  always #2 core_clk = ~core_clk;
  hbms_if bus ();
  hbms_device i_hbms_device (.core_clk, .srst, .bus, .host_if_strap(strap), .bootLoadReq, .bootLoadAddr,
    .bootLoadValid, .bootLoadData, .bootDone, .activeMode);
  hbms_host i_hbms_host (.core_clk, .srst, .bus, .reqValid, .reqReady, .reqWrite, .reqAddr, .reqData,
    .romSelect, .rspValid, .rspData);
  hbms_props i_hbms_props (.core_clk, .srst, .addr(bus.addr), .hostData(bus.hostData), .devData(bus.devData),
    .devDataOe_n(bus.devDataOe_n), .chip_select_n(bus.chip_select_n), .read_write_select(bus.read_write_select),
    .data_transfer_ack(bus.data_transfer_ack), .ackOe_n(bus.ackOe_n), .bootRomCs_n(bus.bootRomCs_n));
  // ****
  // boot rom: the mode word switches to the cs style after loading
  // ****
  always @(negedge core_clk) begin
    bootLoadValid <= bootLoadReq;
    bootLoadData <= (bootLoadAddr == MODE_REG_ADDR) ? {5'h00, STRAP_CS_STYLE} : {1'b0, bootLoadAddr} ^ 8'h5a;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ****
  // tasks
  // ****
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst(logic [2:0] s);
    @(negedge core_clk);
    srst = 1'b1;
    strap = s;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  // called at a falling edge; a read returns at a falling edge with rdData set
  task automatic req(logic wr, logic [6:0] a, logic [7:0] d);
    reqValid = 1'b1;
    reqWrite = wr;
    reqAddr = a;
    reqData = d;
    while (reqReady !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    reqValid = 1'b0;
    if (!wr) begin
      for (int i = 0; i < 200 && rspValid !== 1'b1; i++) @(negedge core_clk);
      chk("read response", {7'h00, rspValid}, 8'h01);
      rdData = rspData;
    end else begin
      @(negedge core_clk);
    end
  endtask
  // ****
  // sequence
  // ****
  initial begin
    rst(STRAP_CS_STYLE);
    chk("mode", {5'h00, activeMode}, {5'h00, STRAP_CS_STYLE});
    strap = STRAP_OFF;
    repeat (3) @(negedge core_clk);
    chk("mode held", {5'h00, activeMode}, {5'h00, STRAP_CS_STYLE});
    romSelect = 1'b1;
    @(negedge core_clk);
    chk("rom select", {7'h00, bus.bootRomCs_n}, 8'h00);
    romSelect = 1'b0;
    for (int i = 0; i < 4; i++) req(1'b1, 7'(8'h20 + i), 8'ha0 ^ 8'(i));
    for (int i = 0; i < 4; i++) begin
      req(1'b0, 7'(8'h20 + i), 8'h00);
      chk("read data", rdData, 8'ha0 ^ 8'(i));
    end
    req(1'b1, MODE_REG_ADDR, 8'h00);
    repeat (60) @(negedge core_clk);
    chk("mode off", {5'h00, activeMode}, {5'h00, STRAP_OFF});
    reqValid = 1'b1;
    reqWrite = 1'b0;
    repeat (30) @(negedge core_clk);
    reqValid = 1'b0;
    chk("ack float", {7'h00, bus.ackOe_n}, 8'h01);
    chk("data float", {7'h00, bus.devDataOe_n}, 8'h01);
    rst(STRAP_BOOT_ROM);
    for (int i = 0; i < 400 && bootDone !== 1'b1; i++) @(negedge core_clk);
    chk("boot done", {7'h00, bootDone}, 8'h01);
    chk("boot mode", {5'h00, activeMode}, {5'h00, STRAP_CS_STYLE});
    req(1'b0, 7'h10, 8'h00);
    chk("boot data", rdData, 8'h10 ^ 8'h5a);
    for (int s = 0; s < 8; s++) begin
      rst(3'(s));
      chk("strap decode", {5'h00, activeMode}, (s == 0 || s > 5) ? 8'h00 : 8'(s));
    end
    conclude();
  end
endmodule
